// file: core/tape_ctrl_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef TAPE_CTRL_MAP_VH
`define TAPE_CTRL_MAP_VH

// ==========================================================
// register byte offsets
`define OFS_CTRL      4'h0
`define OFS_STATUS    4'h4
`define OFS_IRQ_STAT  4'h8
`define OFS_IRQ_MASK  4'hC

// ==========================================================
// control register fields
`define CTRL_LOAD     0
`define CTRL_REWIND   1
`define CTRL_REC_SEL  2

// ==========================================================
// status register fields
`define ST_FORWARD    0
`define ST_READY      1
`define ST_REWIND     2
`define ST_OSC_REQ    3
`define ST_SETTLED    4
`define ST_BREAK      5
`define ST_START      6

// ==========================================================
// interrupt event fields
`define EV_READY      0
`define EV_BREAK      1
`define EV_REW_DONE   2
`define EV_WIDTH      3

// ==========================================================
// reset values
`define CTRL_RESET    32'h0000_0000
`define MASK_RESET    32'h0000_0000

// ==========================================================
// timing, ns and cycles at 250 MHz
`define CLK_PERIOD_NS 4
`define POR_TIME_NS   1000000
`define POR_CYCLES    (`POR_TIME_NS / `CLK_PERIOD_NS)
`define OSC_DLY_NS    100000
`define OSC_DLY_CYC   (`OSC_DLY_NS / `CLK_PERIOD_NS)

`endif

// file: core/sync2.v
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ns
module sync2 #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;   // first stage, read only by second
  reg [W-1:0] q_ff;      // second stage

  // ==========================================================
  // shift chain
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= {W{1'b0}};
      q_ff    <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // sync2

// file: core/delay_cnt.v
// restartable delay counter: done rises after len cycles of run
`timescale 1ns/1ns
module delay_cnt #(
  parameter W = 24
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         run,
  input  wire [W-1:0] len,
  output wire         done
);
  reg [W-1:0] cnt_ff;    // cycles elapsed while run is high
  reg         done_ff;   // delay expired
  wire [W-1:0] nxt_cnt;

  assign nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};

  // ==========================================================
  // count while run, clear when run drops
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_ff  <= {W{1'b0}};
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      cnt_ff  <= nxt_cnt;
      done_ff <= (nxt_cnt >= len);
    end
  end

  assign done = done_ff;
endmodule // delay_cnt

// file: core/tape_load_rewind_control.v
// tape transport load and rewind sequencer with axi4-lite registers
`timescale 1ns/1ns
`include "tape_ctrl_map.vh"
module tape_load_rewind_control #(
  parameter POR_CYCLES = `POR_CYCLES,
  parameter OSC_CYCLES = `OSC_DLY_CYC,
  parameter CW         = 24
) (
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // panel and interface commands, active low except record_select, which is active high
  input  wire        panel_load_n,
  input  wire        intf_load_n,
  input  wire        panel_rewind_n,
  input  wire        intf_rewind_n,
  input  wire        record_select,
  // transport sensors
  input  wire        tape_start_detect,
  input  wire        tape_break_sense,
  // transport outputs
  output wire        advance_relay_drive,
  output wire        rewind_relay_drive,
  output wire        forward_lamp_n,
  output wire        rewind_lamp,
  output wire        break_lamp_n,
  output wire        step_osc_go_n,
  output wire        record_armed,
  output wire        head_supply_en,
  output wire        tape_start_mark,
  output wire        irq
);
  // ==========================================================
  // input synchronisation
  wire [6:0] sync_q;      // synchronised sensor and command levels
  wire       s_pload;     // panel load, active high after inversion
  wire       s_iload;     // interface load, active high
  wire       s_prew;      // panel rewind, active high
  wire       s_irew;      // interface rewind, active high
  wire       s_rec_sel;
  wire       s_start;
  wire       s_break;

  sync2 #(.W(7)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    // active-low commands are inverted first so that the chain's
    // cleared state reads as idle and no false command follows reset
    .d       ({!panel_load_n, !intf_load_n, !panel_rewind_n,
               !intf_rewind_n, record_select, tape_start_detect,
               tape_break_sense}),
    .q       (sync_q)
  );
  assign {s_pload, s_iload, s_prew, s_irew,
          s_rec_sel, s_start, s_break} = sync_q;

  // ==========================================================
  // register state
  localparam [31:0] CTRL_RST = `CTRL_RESET;  // control reset word
  localparam [31:0] MASK_RST = `MASK_RESET;  // mask reset word
  reg  [2:0]          ctrl_ff;      // software load, rewind, rec select
  reg  [`EV_WIDTH-1:0] ist_ff;      // sticky event bits
  reg  [`EV_WIDTH-1:0] imask_ff;    // event enables
  reg                 fwd_ff;       // forward flag
  reg                 rdy_ff;       // ready flag
  reg                 rew_ff;       // rewind flag
  reg                 req_ff;       // oscillator request held
  reg                 rdy_d_ff;     // ready one cycle ago
  reg                 brk_d_ff;     // break one cycle ago
  reg                 rew_d_ff;     // rewind one cycle ago

  // ==========================================================
  // command merge: software bits act like the panel buttons
  wire load_cmd = s_pload || s_iload || ctrl_ff[`CTRL_LOAD];
  wire rew_cmd  = s_prew || s_irew || ctrl_ff[`CTRL_REWIND];
  wire rec_sel  = s_rec_sel || ctrl_ff[`CTRL_REC_SEL];

  // ==========================================================
  // timers
  wire settled;     // power-on settling over
  wire osc_ok;      // settling before oscillator start over

  delay_cnt #(.W(CW)) u_por (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (1'b1),
    .len     (POR_CYCLES[CW-1:0]),
    .done    (settled)
  );

  delay_cnt #(.W(CW)) u_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (fwd_ff && !rdy_ff && !rew_ff),
    .len     (OSC_CYCLES[CW-1:0]),
    .done    (osc_ok)
  );

  // ==========================================================
  // forward clear causes: settling, break, start during rewind
  wire fwd_clr = !settled
               || s_break
               || (rew_ff && s_start);

  // ==========================================================
  // transport flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      fwd_ff <= 1'b0;
      rdy_ff <= 1'b0;
      rew_ff <= 1'b0;
    end else if (fwd_clr || !fwd_ff) begin
      // forward clear drags the other flags down
      fwd_ff <= !fwd_clr && load_cmd;
      rdy_ff <= 1'b0;
      rew_ff <= 1'b0;
    end else begin
      if (rew_cmd) begin
        rew_ff <= 1'b1;
        rdy_ff <= 1'b0;
      end else if (!rew_ff && s_start) begin
        rdy_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // oscillator request: set after delay, drop when ready and
  // load released, cleared at the first edge in rewind or break
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_ff <= 1'b0;
    end else if (!fwd_ff || rew_ff || s_break) begin
      req_ff <= 1'b0;
    end else if (rdy_ff && !load_cmd) begin
      req_ff <= 1'b0;
    end else if (!rdy_ff && osc_ok) begin
      req_ff <= 1'b1;
    end
  end

  // ==========================================================
  // outputs; outside gap logic may keep the oscillator running after step_osc_go_n rises
  assign advance_relay_drive = fwd_ff;
  assign forward_lamp_n      = !fwd_ff;
  assign rewind_relay_drive  = rew_ff && fwd_ff;
  assign rewind_lamp         = rew_ff && fwd_ff;
  assign break_lamp_n        = !s_break;
  assign step_osc_go_n       = !req_ff;
  assign record_armed        = rdy_ff && rec_sel;
  assign head_supply_en      = rdy_ff && rec_sel;
  assign tape_start_mark     = s_start;

  // ==========================================================
  // event detection
  wire [`EV_WIDTH-1:0] ev;
  assign ev[`EV_READY]    = rdy_ff && !rdy_d_ff;
  assign ev[`EV_BREAK]    = s_break && !brk_d_ff;
  assign ev[`EV_REW_DONE] = !rew_ff && rew_d_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rdy_d_ff <= 1'b0;
      brk_d_ff <= 1'b0;
      rew_d_ff <= 1'b0;
    end else begin
      rdy_d_ff <= rdy_ff;
      brk_d_ff <= s_break;
      rew_d_ff <= rew_ff;
    end
  end

  assign irq = |(ist_ff & imask_ff);

  // ==========================================================
  // axi4-lite write channel
  reg        aw_ff;        // address taken
  reg        w_ff;         // data taken
  reg [3:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg        bvalid_ff;
  reg [1:0]  bresp_ff;

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  wire do_wr = aw_ff && w_ff && !bvalid_ff;
  wire wr_ctrl = do_wr && awaddr_ff == `OFS_CTRL && wstrb_ff[0];
  wire wr_ist  = do_wr && awaddr_ff == `OFS_IRQ_STAT && wstrb_ff[0];
  wire wr_mask = do_wr && awaddr_ff == `OFS_IRQ_MASK && wstrb_ff[0];
  wire wr_ok   = awaddr_ff == `OFS_CTRL || awaddr_ff == `OFS_STATUS ||
                 awaddr_ff == `OFS_IRQ_STAT ||
                 awaddr_ff == `OFS_IRQ_MASK;

  // capture address and data in either order, answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? 2'b00 : 2'b10;   // slverr if unmapped
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software registers; hardware set wins over write-one-clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= CTRL_RST[2:0];
      imask_ff <= MASK_RST[`EV_WIDTH-1:0];
      ist_ff   <= {`EV_WIDTH{1'b0}};
    end else begin
      if (wr_ctrl)
        ctrl_ff <= wdata_ff[2:0];
      if (wr_mask)
        imask_ff <= wdata_ff[`EV_WIDTH-1:0];
      if (wr_ist)
        ist_ff <= (ist_ff & ~wdata_ff[`EV_WIDTH-1:0]) | ev;
      else
        ist_ff <= ist_ff | ev;
    end
  end

  // ==========================================================
  // axi4-lite read channel
  reg        rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0]  rresp_ff;
  reg [31:0] rd_mux;
  reg        rd_ok;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // read data select
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[3:2], 2'b00})
      `OFS_CTRL:     rd_mux[2:0] = ctrl_ff;
      `OFS_STATUS:   rd_mux[6:0] = {s_start, s_break, settled, req_ff,
                                    rew_ff, rdy_ff, fwd_ff};
      `OFS_IRQ_STAT: rd_mux[`EV_WIDTH-1:0] = ist_ff;
      `OFS_IRQ_MASK: rd_mux[`EV_WIDTH-1:0] = imask_ff;
      default:       rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'b00;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_ok ? 2'b00 : 2'b10;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule // tape_load_rewind_control

// file: testbench/tape_ctrl_chk.sv
// assertion checker for the tape transport sequencer
`timescale 1ns/1ns
module tape_ctrl_chk #(
  parameter POR_CYCLES = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire tape_start_detect,
  input wire tape_break_sense,
  input wire advance_relay_drive,
  input wire rewind_relay_drive,
  input wire forward_lamp_n,
  input wire rewind_lamp,
  input wire break_lamp_n,
  input wire step_osc_go_n,
  input wire record_armed,
  input wire head_supply_en,
  input wire tape_start_mark
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // edges since reset release, saturating
  reg [31:0] up_ff;
  always @(posedge aclk) begin
    if (!aresetn) up_ff <= 32'h0000_0000;
    else if (up_ff < POR_CYCLES + 2) up_ff <= up_ff + 32'h0000_0001;
  end
  reset_clear_a: assert property (
    $rose(aresetn) |-> !advance_relay_drive && step_osc_go_n && !rewind_lamp)
    else $error("flags not clear after reset");
  por_hold_a: assert property (
    up_ff < POR_CYCLES |-> !advance_relay_drive)
    else $error("forward set during settling");
  relay_lock_a: assert property (
    rewind_relay_drive |-> advance_relay_drive)
    else $error("rewind relay without advance relay");
  fwd_lamp_a: assert property (
    forward_lamp_n == !advance_relay_drive)
    else $error("forward lamp wrong");
  rew_relay_a: assert property (
    rewind_lamp == rewind_relay_drive)
    else $error("rewind lamp and relay differ");
  rew_osc_a: assert property (
    rewind_lamp && $past(rewind_lamp) |-> step_osc_go_n)
    else $error("oscillator run during rewind");
  rew_arm_a: assert property (
    rewind_lamp && $past(rewind_lamp) |-> !record_armed && !head_supply_en)
    else $error("write armed during rewind");
  arm_head_a: assert property (
    record_armed == head_supply_en)
    else $error("head supply differs from armed");
  brk_lamp_a: assert property (
    $rose(tape_break_sense) |-> ##[1:3] !break_lamp_n)
    else $error("break lamp late");
  brk_fwd_a: assert property (
    tape_break_sense [*4] |-> !advance_relay_drive)
    else $error("forward held during break");
  brk_osc_a: assert property (
    !break_lamp_n && !$past(break_lamp_n) |-> step_osc_go_n)
    else $error("oscillator run during break");
  start_mark_a: assert property (
    tape_start_mark == $past(tape_start_detect, 2))
    else $error("start marker not following detector");
  osc_delay_a: assert property (
    $rose(advance_relay_drive) |-> step_osc_go_n [*3])
    else $error("oscillator request without delay");
endmodule // tape_ctrl_chk

bind tape_load_rewind_control tape_ctrl_chk #(
  .POR_CYCLES(POR_CYCLES)
) u_chk (.*);

// file: testbench/tape_far_end.sv
// behavioural tape transport: marker position and break sensor
`timescale 1ns/1ns
module tape_far_end #(
  parameter LEAD = 8, // steps from the reel start to the marker
  parameter GAP  = 6  // steps the gap timer adds after the request
) (
  input wire aclk,
  input wire step_osc_go_n,
  input wire rewind_relay_drive,
  input wire snap,
  output wire tape_start_detect,
  output wire tape_break_sense
);
  integer pos_ff = 0; // tape position in steps
  integer gap_ff = 0; // gap steps still owed
  reg go_d_ff = 1'b1; // request one cycle ago, active low
  wire run; // oscillator running, from the block or the gap timer
  // gap timer keeps the oscillator running past the marker after
  // the control block withdraws its request
  always @(posedge aclk) begin
    go_d_ff <= step_osc_go_n;
    if (step_osc_go_n && !go_d_ff && pos_ff > LEAD) begin
      gap_ff <= GAP;
    end else if (gap_ff > 0) begin
      gap_ff <= gap_ff - 1;
    end
  end
  assign run = !step_osc_go_n || (gap_ff > 0);
  // tape steps forward while running, back while rewinding
  always @(posedge aclk) begin
    if (run) begin
      pos_ff <= pos_ff + 1;
    end else if (rewind_relay_drive && pos_ff > LEAD) begin
      pos_ff <= pos_ff - 1;
    end
  end
  // marker seen only at its own position
  assign tape_start_detect = (pos_ff == LEAD);
  assign tape_break_sense = snap;
endmodule // tape_far_end

// file: testbench/testbench.sv
// self-checking bench for the tape transport sequencer
`timescale 1ns/1ns
module testbench;
  // ==========
  // design inputs
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [3:0] s_axi_awaddr = 4'h0;
  reg [3:0] s_axi_araddr = 4'h0;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg panel_load_n = 1'b1;
  reg intf_load_n = 1'b1;
  reg panel_rewind_n = 1'b1;
  reg intf_rewind_n = 1'b1;
  reg record_select = 1'b1;
  reg snap = 1'b0; // break request to the transport
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, tape_start_detect, tape_break_sense, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire advance_relay_drive, rewind_relay_drive, forward_lamp_n;
  wire rewind_lamp, break_lamp_n, step_osc_go_n, record_armed;
  wire head_supply_en, tape_start_mark;
  integer failures = 0;
  integer num_checks = 0;
  reg [31:0] rd; // last read data
  reg [1:0] rr; // last read response
  reg [1:0] br; // last write response
  always #2 aclk = ~aclk;
  tape_load_rewind_control #(.POR_CYCLES(16), .OSC_CYCLES(4)) DUT (.*);
  tape_far_end #(.LEAD(8)) u_far (.*);
  // ==========
  // helpers
  task chk(input [31:0] g, input [31:0] e, input [8*9:1] m);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %0t %0s got %h", $time, m, g);
      end
    end
  endtask
  function sg(input [2:0] s);
    case (s)
      3'd0: sg = advance_relay_drive;
      3'd1: sg = step_osc_go_n;
      3'd2: sg = record_armed;
      3'd3: sg = rewind_lamp;
      default: sg = break_lamp_n;
    endcase
  endfunction
  // bounded wait for a selected output to reach a level
  task wt(input [2:0] s, input v, input [8*9:1] m);
    integer n;
    begin
      n = 0;
      while (sg(s) !== v && n < 200) begin
        @(posedge aclk);
        n = n + 1;
      end
      chk(sg(s), v, m);
    end
  endtask
  // register write, address and data offered together; each channel
  // is released at the edge that takes it, response taken into br
  task wr(input [3:0] a, input [31:0] d);
    reg go;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      go = 1'b1;
      while (go) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) begin
          br = s_axi_bresp;
          s_axi_bready <= 1'b0;
          go = 1'b0;
        end
      end
    end
  endtask
  // register read into rd and rr, taken at the handshake edge
  task rdr(input [3:0] a);
    reg go;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      go = 1'b1;
      while (go) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) begin
          rd = s_axi_rdata;
          rr = s_axi_rresp;
          s_axi_rready <= 1'b0;
          go = 1'b0;
        end
      end
    end
  endtask
  // ==========
  // scenarios
  task t_reset;
    begin
      repeat (12) @(posedge aclk);
      chk(advance_relay_drive, 0, "por");
      chk(step_osc_go_n, 1, "osc rst");
      rdr(4'h0);
      chk(rd, 32'h0000_0000, "ctrl rst");
      rdr(4'hc);
      chk(rd, 32'h0000_0000, "mask rst");
      rdr(4'h2);
      chk(rr, 2'b00, "low bits");
      $display("reset test done");
    end
  endtask
  task t_load;
    begin
      wt(0, 1, "fwd");
      chk(forward_lamp_n, 0, "lamp");
      wt(1, 0, "osc on");
      wt(2, 1, "armed");
      chk(head_supply_en, 1, "head");
      chk(step_osc_go_n, 0, "osc held");
      record_select <= 1'b0;
      wt(2, 0, "rec off");
      wr(4'h0, 32'h0000_0004);
      chk(record_armed, 1, "sw rec");
      record_select <= 1'b1;
      wr(4'h0, 32'h0000_0000);
      rdr(4'h4);
      chk(rd[2:0], 3'b011, "status");
      rdr(4'h8);
      chk(rd[0], 1, "ev ready");
      chk(irq, 0, "irq mask");
      wr(4'hc, 32'h0000_0001);
      chk(br, 2'b00, "bresp");
      chk(irq, 1, "irq on");
      wr(4'h8, 32'h0000_0001);
      chk(irq, 0, "irq clr");
      panel_load_n <= 1'b1;
      wt(1, 1, "osc off");
      $display("load test done");
    end
  endtask
  task t_rewind;
    begin
      intf_rewind_n <= 1'b0;
      wt(3, 1, "rew on");
      intf_rewind_n <= 1'b1;
      @(posedge aclk);
      chk(rewind_relay_drive, 1, "rw relay");
      chk(record_armed, 0, "disarm");
      chk(step_osc_go_n, 1, "osc rew");
      wt(0, 0, "rew end");
      chk(rewind_lamp, 0, "lamp off");
      chk(tape_start_mark, 1, "mark");
      rdr(4'h8);
      chk(rd[2], 1, "ev rew");
      $display("rewind test done");
    end
  endtask
  task t_break;
    begin
      wr(4'h0, 32'h0000_0001);
      wt(0, 1, "sw load");
      snap <= 1'b1;
      wt(4, 0, "brk lamp");
      wt(0, 0, "brk fwd");
      chk(step_osc_go_n, 1, "brk osc");
      chk(record_armed, 0, "brk arm");
      rdr(4'h8);
      chk(rd[1], 1, "ev brk");
      snap <= 1'b0;
      wr(4'h0, 32'h0000_0000);
      $display("break test done");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    panel_load_n <= 1'b0;
    t_reset;
    t_load;
    t_rewind;
    t_break;
    end_of_test;
  end
  // watchdog
  initial begin
    #40000;
    failures = failures + 1;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test;
  end
endmodule // testbench
